// file: verilog/timer8_compare_waveform.sv
`include "timer8_defines.svh"
`default_nettype none
module timer8_compare_waveform (
  input wire logic clk,
  input wire logic rst,
  input wire timer8_pkg::ahb_req_t ahbReq,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic timerTick,
  input wire logic overflowAck,
  input wire logic matchAck,
  input wire logic portData,
  input wire logic wavePinDirBit,
  output logic pinOut,
  output logic pinOe_n,
  output logic overflowFlag,
  output logic matchFlag
);
  import timer8_pkg::*;

  timer_state_t st; // Registered state
  timer_state_t next_st; // Next state
  logic [2:0] rdIdx; // Register addressed by a read
  logic [31:0] rdWord; // Read mux output
  logic wrStrobe; // Write data phase
  logic [2:0] wrIdx; // Register being written
  logic [31:0] wrData; // Write data
  logic ctrlWr; // Control written
  logic countWr; // Counter written
  logic compareWr; // Compare written
  logic flagsWr; // Flags written
  logic pwmMode; // Mode uses double buffering
  logic matchRaw; // Comparator equal
  logic matchHit; // Comparator match not blocked
  logic atMax; // Counter at maximum
  logic forceHit; // Force strobe taking effect
  logic setOvf; // Overflow event this cycle
  logic setMatch; // Match event this cycle

  // Bus slave
  ahb_reg_slave u_slave (
    .clk(clk),
    .rst(rst),
    .ahbReq(ahbReq),
    .rdWord(rdWord),
    .rdIdx(rdIdx),
    .wrStrobe(wrStrobe),
    .wrIdx(wrIdx),
    .wrData(wrData),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp)
  );

  // Wave state after an action at a match or force
  function automatic logic matchAction(input out_action_t act, input logic cur);
    logic res;
    res = cur;
    unique case (act)
      ACT_NONE: res = cur;
      ACT_TOGGLE: res = ~cur;
      ACT_CLEAR: res = 1'b0;
      ACT_SET: res = 1'b1;
    endcase
    return res;
  endfunction : matchAction

  // Write decode
  always_comb begin
    ctrlWr = wrStrobe && (wrIdx == `REG_CTRL);
    countWr = wrStrobe && (wrIdx == `REG_COUNT);
    compareWr = wrStrobe && (wrIdx == `REG_COMPARE);
    flagsWr = wrStrobe && (wrIdx == `REG_FLAGS);
  end

  // Comparator and events
  always_comb begin
    pwmMode = st.waveModeSel[0];
    matchRaw = (st.countValue == st.compareValue);
    matchHit = matchRaw && !st.blockMatch;
    atMax = (st.countValue == `COUNT_MAX);
    forceHit = ctrlWr && wrData[`CTRL_FORCE_BIT] && !wrData[`CTRL_MODE_LSB];
    setOvf = timerTick && atMax;
    setMatch = timerTick && matchHit;
  end

  // Next state
  always_comb begin
    next_st = st;
    if (timerTick) begin
      next_st.blockMatch = 1'b0;
      unique case (st.waveModeSel)
        MODE_NORMAL: next_st.countValue = st.countValue + `COUNT_ONE;
        MODE_PHASE: next_st.countValue = st.countValue + `COUNT_ONE;
        MODE_CTC: begin
          if (matchHit) begin
            next_st.countValue = `COUNT_BOTTOM;
          end else begin
            next_st.countValue = st.countValue + `COUNT_ONE;
          end
        end
        MODE_FAST: next_st.countValue = st.countValue + `COUNT_ONE;
      endcase
      if (matchHit && (st.waveModeSel != MODE_PHASE)) begin
        next_st.waveOut = matchAction(st.outActionSel, st.waveOut);
      end
      if ((st.waveModeSel == MODE_FAST) && atMax) begin
        if (st.outActionSel == ACT_CLEAR) begin
          next_st.waveOut = 1'b1;
        end else if (st.outActionSel == ACT_SET) begin
          next_st.waveOut = 1'b0;
        end
      end
      if (pwmMode && atMax) begin
        next_st.compareValue = st.compareBuffer;
      end
    end
    if (countWr) begin
      next_st.countValue = wrData[7:0];
      next_st.blockMatch = 1'b1;
    end
    if (compareWr) begin
      next_st.compareBuffer = wrData[7:0];
      if (!pwmMode) begin
        next_st.compareValue = wrData[7:0];
      end
    end
    if (ctrlWr) begin
      next_st.waveModeSel = wave_mode_t'(wrData[`CTRL_MODE_MSB:`CTRL_MODE_LSB]);
      next_st.outActionSel = out_action_t'(wrData[`CTRL_ACT_MSB:`CTRL_ACT_LSB]);
    end
    if (forceHit) begin
      next_st.waveOut = matchAction(
        out_action_t'(wrData[`CTRL_ACT_MSB:`CTRL_ACT_LSB]), next_st.waveOut);
    end
    next_st.overflowFlag = (st.overflowFlag
      && !(flagsWr && wrData[`FLAG_OVF_BIT]) && !overflowAck) || setOvf;
    next_st.matchFlag = (st.matchFlag
      && !(flagsWr && wrData[`FLAG_MATCH_BIT]) && !matchAck) || setMatch;
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Read mux
  always_comb begin
    unique case (rdIdx)
      `REG_CTRL: rdWord = {`PAD24, 4'h0, st.outActionSel, st.waveModeSel};
      `REG_COUNT: rdWord = {`PAD24, st.countValue};
      `REG_COMPARE: rdWord = {`PAD24, st.compareBuffer};
      `REG_FLAGS: rdWord = {`PAD30, st.matchFlag, st.overflowFlag};
      `REG_STATUS: rdWord = {`PAD24, st.compareValue} | {`PAD30, st.blockMatch, st.waveOut} << 8;
      default: rdWord = `WORD_ZERO;
    endcase
  end

  // Pin override and direction
  always_comb begin
    pinOut = (st.outActionSel != ACT_NONE) ? st.waveOut : portData;
    pinOe_n = ~wavePinDirBit;
  end

  assign overflowFlag = st.overflowFlag;
  assign matchFlag = st.matchFlag;

  // Checks
  property p_block_set;
    @(posedge clk) disable iff (rst) countWr |=> st.blockMatch;
  endproperty
  a_block_set: assert property (p_block_set) else $error("count write did not block");

  property p_block_flag;
    @(posedge clk) disable iff (rst)
      (timerTick && st.blockMatch && !st.matchFlag) |=> !st.matchFlag;
  endproperty
  a_block_flag: assert property (p_block_flag) else $error("blocked match set flag");

  property p_mode_keep;
    @(posedge clk) disable iff (rst)
      (ctrlWr && !forceHit && !timerTick) |=> $stable(st.waveOut);
  endproperty
  a_mode_keep: assert property (p_mode_keep) else $error("mode change moved wave");

  property p_pin;
    @(posedge clk) disable iff (rst)
      (st.outActionSel != ACT_NONE) |-> (pinOut == st.waveOut && pinOe_n == !wavePinDirBit);
  endproperty
  a_pin: assert property (p_pin) else $error("pin not driven by wave");

  property p_normal_inc;
    @(posedge clk) disable iff (rst)
      (timerTick && st.waveModeSel == MODE_NORMAL && !countWr && !ctrlWr)
      |=> st.countValue == $past(st.countValue) + `COUNT_ONE;
  endproperty
  a_normal_inc: assert property (p_normal_inc) else $error("normal count wrong");

  property p_ovf;
    @(posedge clk) disable iff (rst) (timerTick && atMax) |=> st.overflowFlag;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag missed");

  property p_ctc_clear;
    @(posedge clk) disable iff (rst)
      (timerTick && st.waveModeSel == MODE_CTC && matchHit && !countWr)
      |=> st.countValue == `COUNT_BOTTOM;
  endproperty
  a_ctc_clear: assert property (p_ctc_clear) else $error("ctc clear missed");

  property p_fast_bottom;
    @(posedge clk) disable iff (rst)
      (timerTick && st.waveModeSel == MODE_FAST && st.outActionSel == ACT_CLEAR
       && atMax && !ctrlWr) |=> st.waveOut;
  endproperty
  a_fast_bottom: assert property (p_fast_bottom) else $error("bottom set missed");

  property p_match_flag;
    @(posedge clk) disable iff (rst) (timerTick && matchHit) |=> st.matchFlag;
  endproperty
  a_match_flag: assert property (p_match_flag) else $error("match flag missed");

  property p_force_only;
    @(posedge clk) disable iff (rst)
      (forceHit && !timerTick && !countWr) ##1 1'b1
      |-> ($stable(st.matchFlag) || !st.matchFlag) && $stable(st.countValue);
  endproperty
  a_force_only: assert property (p_force_only) else $error("force touched counter");

  c_ctc: cover property (@(posedge clk) disable iff (rst)
    timerTick && st.waveModeSel == MODE_CTC && matchHit);
  c_fast_wrap: cover property (@(posedge clk) disable iff (rst)
    timerTick && st.waveModeSel == MODE_FAST && atMax);
  c_force: cover property (@(posedge clk) disable iff (rst) forceHit);
  c_block: cover property (@(posedge clk) disable iff (rst)
    timerTick && st.blockMatch && matchRaw);
endmodule : timer8_compare_waveform
`default_nettype wire

// file: verilog/timer8_defines.svh
// What this block does
// - Count write blocks matches for one tick
// - Mode change leaves wave state untouched
// - Action select applies from next match
// - Reset clears wave state to zero
// - Nonzero action routes wave state to pin
// - Action zero leaves wave state unchanged
// - Force strobe applies action in non-PWM modes
// - Normal mode counts up and wraps
// - Normal mode sets overflow on wrap
// - Clear-on-match mode clears counter at match
// - Clear-on-match compare writes apply at once
// - Clear-on-match action one toggles output
// - Clear-on-match overflow set on max wrap
// - Fast PWM counts to max, restarts
// - Fast PWM clears/sets at match and bottom
// - Fast PWM overflow set at maximum
// - Fast PWM extremes give spike or constant
// - Fast PWM toggle keeps compare buffered
// - Match sets match flag; write-one clears
// - PWM compare writes buffered, else direct
// - Force touches only the wave state
`ifndef TIMER8_DEFINES_SVH
`define TIMER8_DEFINES_SVH
// Register indexes, byte address is index times four
`define REG_CTRL 3'h0
`define REG_COUNT 3'h1
`define REG_COMPARE 3'h2
`define REG_FLAGS 3'h3
`define REG_STATUS 3'h4
// Field positions
`define CTRL_MODE_LSB 0
`define CTRL_MODE_MSB 1
`define CTRL_ACT_LSB 2
`define CTRL_ACT_MSB 3
`define CTRL_FORCE_BIT 7
`define FLAG_OVF_BIT 0
`define FLAG_MATCH_BIT 1
// Counter extremes and reset values
`define COUNT_MAX 8'hff
`define COUNT_BOTTOM 8'h00
`define COUNT_ONE 8'h01
`define BYTE_RESET 8'h00
`define WORD_ZERO 32'h0000_0000
`define PAD24 24'h00_0000
`define PAD27 27'h000_0000
`define PAD30 30'h0000_0000
// Bus codes
`define HTRANS_NONSEQ 2'b10
`define HRESP_OKAY 1'b0
`endif

// file: verilog/timer8_pkg.sv
`default_nettype none
package timer8_pkg;
  // Waveform modes, bit 0 marks the PWM modes
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_PHASE = 2'b01,
    MODE_CTC = 2'b10,
    MODE_FAST = 2'b11
  } wave_mode_t;
  // Output actions
  typedef enum logic [1:0] {
    ACT_NONE = 2'b00,
    ACT_TOGGLE = 2'b01,
    ACT_CLEAR = 2'b10,
    ACT_SET = 2'b11
  } out_action_t;
  // AHB-Lite request from the master
  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } ahb_req_t;
  // Timer state
  typedef struct packed {
    wave_mode_t waveModeSel;
    out_action_t outActionSel;
    logic [7:0] countValue;
    logic [7:0] compareValue;
    logic [7:0] compareBuffer;
    logic overflowFlag;
    logic matchFlag;
    logic waveOut;
    logic blockMatch;
  } timer_state_t;
  // Bus slave state
  typedef struct packed {
    logic wrPend;
    logic [2:0] wrIdx;
    logic [31:0] hrdata;
  } slave_state_t;
endpackage : timer8_pkg
`default_nettype wire

// file: verilog/ahb_reg_slave.sv
`include "timer8_defines.svh"
`default_nettype none
module ahb_reg_slave (
  input wire logic clk,
  input wire logic rst,
  input wire timer8_pkg::ahb_req_t ahbReq,
  input wire logic [31:0] rdWord,
  output logic [2:0] rdIdx,
  output logic wrStrobe,
  output logic [2:0] wrIdx,
  output logic [31:0] wrData,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp
);
  import timer8_pkg::*;
  slave_state_t st; // Registered state
  slave_state_t next_st; // Next state
  logic take; // Valid address phase

  // Address phase decode
  always_comb begin
    take = ahbReq.hsel && ahbReq.hready && (ahbReq.htrans == `HTRANS_NONSEQ);
    next_st = st;
    next_st.wrPend = take && ahbReq.hwrite;
    if (take) begin
      next_st.wrIdx = ahbReq.haddr[4:2];
    end
    // Read data captured at the address phase
    if (take && !ahbReq.hwrite) begin
      next_st.hrdata = rdWord;
    end
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rdIdx = ahbReq.haddr[4:2];
  assign wrStrobe = st.wrPend;
  assign wrIdx = st.wrIdx;
  assign wrData = ahbReq.hwdata;
  assign hrdata = st.hrdata;
  assign hreadyout = 1'b1;
  assign hresp = `HRESP_OKAY;
endmodule : ahb_reg_slave
`default_nettype wire

// file: tb/port_pin_model.sv
`default_nettype none
module port_pin_model (
  input wire logic pinOut,
  input wire logic pinOe_n,
  output logic padLevel
);
  timeunit 1ns;
  timeprecision 100ps;
  // Pull-up holds the pad high while released
  assign padLevel = pinOe_n ? 1'b1 : pinOut;
endmodule : port_pin_model
`default_nettype wire

// file: tb/timer8_compare_waveform_test.sv
`include "timer8_defines.svh"
`default_nettype none
module timer8_compare_waveform_test;
  timeunit 1ns;
  timeprecision 100ps;
  import timer8_pkg::*;
  // Bus master and side inputs
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sel = 1'b0;
  logic wr = 1'b0;
  logic [1:0] trans = 2'b00;
  logic [31:0] addr = 32'h0;
  logic [31:0] wdata = 32'h0;
  logic tickEn = 1'b0;
  logic ovfAck = 1'b0;
  logic matchAck = 1'b0;
  logic portData = 1'b0;
  logic dirBit = 1'b0;
  // Design outputs
  logic [31:0] hrdata;
  logic hreadyout, hresp, pinOut, pinOe_n, overflowFlag, matchFlag, padLevel;
  ahb_req_t ahbReq;
  int nMismatch = 0;
  int testsRun = 0;
  // One slave, so its ready is the bus ready
  assign ahbReq = {sel, addr, trans, wr, 3'h2, wdata, hreadyout};
  always #25 clk = ~clk;
  timer8_compare_waveform dut_u (.clk(clk), .rst(rst), .ahbReq(ahbReq), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .timerTick(tickEn), .overflowAck(ovfAck),
    .matchAck(matchAck), .portData(portData), .wavePinDirBit(dirBit), .pinOut(pinOut),
    .pinOe_n(pinOe_n), .overflowFlag(overflowFlag), .matchFlag(matchFlag));
  port_pin_model pin_u (.pinOut(pinOut), .pinOe_n(pinOe_n), .padLevel(padLevel));
  // Pin and flag snapshot
  function automatic logic [31:0] pins();
    return {27'h0, pinOut, pinOe_n, padLevel, matchFlag, overflowFlag};
  endfunction : pins
  function automatic logic [31:0] ctl(logic f, out_action_t a, wave_mode_t m);
    return {24'h0, f, 3'h0, a, m};
  endfunction : ctl
  // Single word transfer, waits on ready in both phases
  task automatic xfer(input logic w, input logic [2:0] idx, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk);
    sel <= 1'b1;
    addr <= {27'h0, idx, 2'b00};
    trans <= 2'b10;
    wr <= w;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    sel <= 1'b0;
    trans <= 2'b00;
    wdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    q = hrdata;
  endtask : xfer
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      $display("ERROR at %0t got %h exp %h", $time, got, exp);
      nMismatch++;
    end
  endtask : chk
  task automatic wreg(input logic [2:0] idx, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, idx, d, q);
    @(negedge clk);
  endtask : wreg
  task automatic rchk(input logic [2:0] idx, input logic [31:0] exp);
    logic [31:0] q;
    xfer(1'b0, idx, 32'h0, q);
    chk(q, exp);
  endtask : rchk
  // Exactly n tick edges, then settle
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk);
      tickEn <= 1'b1;
    end
    @(posedge clk);
    tickEn <= 1'b0;
    @(negedge clk);
  endtask : tick
  task automatic ack(input logic o, input logic m);
    @(posedge clk);
    ovfAck <= o;
    matchAck <= m;
    @(posedge clk);
    ovfAck <= 1'b0;
    matchAck <= 1'b0;
    @(negedge clk);
  endtask : ack
  task automatic test_reset();
    rchk(`REG_CTRL, 32'h0);
    rchk(`REG_STATUS, 32'h0);
    wreg(3'h7, 32'hffff_ffff);
    rchk(3'h7, 32'h0);
    chk(pins(), 32'h0c);
    // Slave always answers OKAY
    chk({31'h0, hresp}, 32'h0);
    $display("test reset done");
  endtask : test_reset
  task automatic test_normal();
    wreg(`REG_COUNT, 32'hfe);
    tick(2);
    chk(pins(), 32'h0d);
    rchk(`REG_COUNT, 32'h0);
    ack(1'b1, 1'b0);
    chk(pins(), 32'h0c);
    $display("test normal done");
  endtask : test_normal
  task automatic test_ctc();
    // wave state cleared by force before pin output
    wreg(`REG_CTRL, ctl(1'b1, ACT_CLEAR, MODE_NORMAL));
    rchk(`REG_STATUS, 32'h000);
    wreg(`REG_CTRL, ctl(1'b0, ACT_TOGGLE, MODE_CTC));
    wreg(`REG_COMPARE, 32'h3);
    wreg(`REG_COUNT, 32'h0);
    @(posedge clk);
    dirBit <= 1'b1;
    tick(4);
    chk(pins(), 32'h16);
    rchk(`REG_COUNT, 32'h0);
    rchk(`REG_STATUS, 32'h103);
    ack(1'b0, 1'b1);
    chk(pins(), 32'h14);
    $display("test ctc done");
  endtask : test_ctc
  task automatic test_block();
    wreg(`REG_COUNT, 32'h3);
    rchk(`REG_STATUS, 32'h303);
    tick(1);
    chk(pins(), 32'h14);
    rchk(`REG_COUNT, 32'h4);
    tick(252);
    chk(pins(), 32'h15);
    rchk(`REG_COUNT, 32'h0);
    wreg(`REG_FLAGS, 32'h3);
    rchk(`REG_FLAGS, 32'h0);
    $display("test block done");
  endtask : test_block
  task automatic test_force();
    wreg(`REG_CTRL, ctl(1'b1, ACT_CLEAR, MODE_NORMAL));
    chk(pins(), 32'h00);
    wreg(`REG_CTRL, ctl(1'b1, ACT_SET, MODE_NORMAL));
    chk(pins(), 32'h14);
    rchk(`REG_COUNT, 32'h0);
    rchk(`REG_CTRL, ctl(1'b0, ACT_SET, MODE_NORMAL));
    // Force ignored in a PWM mode
    wreg(`REG_CTRL, ctl(1'b1, ACT_CLEAR, MODE_PHASE));
    rchk(`REG_STATUS, 32'h103);
    rchk(`REG_CTRL, ctl(1'b0, ACT_CLEAR, MODE_PHASE));
    wreg(`REG_CTRL, ctl(1'b0, ACT_NONE, MODE_FAST));
    chk(pins(), 32'h00);
    rchk(`REG_STATUS, 32'h103);
    $display("test force done");
  endtask : test_force
  task automatic test_fast();
    wreg(`REG_CTRL, ctl(1'b0, ACT_SET, MODE_FAST));
    wreg(`REG_COMPARE, 32'h80);
    rchk(`REG_STATUS, 32'h103);
    wreg(`REG_COUNT, 32'hfe);
    tick(2);
    chk(pins(), 32'h01);
    rchk(`REG_STATUS, 32'h080);
    tick(129);
    chk(pins(), 32'h17);
    rchk(`REG_COUNT, 32'h81);
    $display("test fast done");
  endtask : test_fast
  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", nMismatch, testsRun);
    if (nMismatch == 0 && testsRun > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test
  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    test_reset();
    test_normal();
    test_ctc();
    test_block();
    test_force();
    test_fast();
    finish_test();
  end
  // Watchdog well past the expected run
  initial begin
    #(20000 * 50);
    nMismatch++;
    finish_test();
  end
endmodule : timer8_compare_waveform_test
`default_nettype wire
